/* File: rffc_amp_model.sv */
// External amplifier and switch model driven by the control pins
`default_nettype none
module rffc_amp_model
(
  input wire logic pa_ctrl_out,
  input wire logic lna_ctrl_out,
  output logic pa_active,
  output logic lna_active
);
  timeunit 1ns;
  timeprecision 1ns;
  // Active-high enables switch the external stages at once
  assign pa_active = pa_ctrl_out;
  assign lna_active = lna_ctrl_out;
endmodule // rffc_amp_model
`default_nettype wire

/* File: rffc_outputs.sv */
// Module: front-end control outputs with register port and lock pin select
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`default_nettype none
module rffc_outputs
  import rffc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic pa_on,
  input wire logic lna_on,
  input wire logic pll_lock,
  output logic pa_ctrl_out,
  output logic lna_ctrl_out,
  output logic lock_out
);

  // Configuration registers
  logic [3:0] iface_r;
  logic [3:0] iface_nxt;
  logic [RFFC_LOCK_SEL_W-1:0] lock_sel_r;
  logic [RFFC_LOCK_SEL_W-1:0] lock_sel_nxt;
  // Pin registers
  logic pa_ctrl_r;
  logic lna_ctrl_r;
  logic lock_r;
  logic pa_ctrl_nxt;
  logic lna_ctrl_nxt;
  logic lock_nxt;
  // Read data register
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  // Address decode
  wire logic hit_iface = (reg_addr == ADDR_W'(RFFC_IFACE_OFS));
  wire logic hit_lock = (reg_addr == ADDR_W'(RFFC_LOCK_OFS));
  wire logic hit_stat = (reg_addr == ADDR_W'(RFFC_STAT_OFS));

  // Named configuration fields
  wire logic pa_follow_sel = iface_r[RFFC_PA_FOLLOW_BIT];
  wire logic lna_follow_sel = iface_r[RFFC_LNA_FOLLOW_BIT];
  wire logic pa_out_level = iface_r[RFFC_PA_LEVEL_BIT];
  wire logic lna_out_level = iface_r[RFFC_LNA_LEVEL_BIT];

  // Register write next values; all four control bits in one word
  assign iface_nxt = (reg_wr && hit_iface) ? reg_wdata[3:0] : iface_r;
  assign lock_sel_nxt = (reg_wr && hit_lock) ?
    reg_wdata[RFFC_LOCK_SEL_LSB +: RFFC_LOCK_SEL_W] : lock_sel_r;

  // PA pin: follow gives level when on, complement when off
  assign pa_ctrl_nxt = pa_follow_sel ?
    (pa_on ? pa_out_level : ~pa_out_level)
    : pa_out_level;

  // LNA pin: same choice as the PA pin
  assign lna_ctrl_nxt = lna_follow_sel ?
    (lna_on ? lna_out_level : ~lna_out_level)
    : lna_out_level;

  // Lock pin source; other codes pass the lock indication through
  assign lock_nxt = (lock_sel_r == RFFC_LOCK_LOW) ? 1'b0 :
    (lock_sel_r == RFFC_LOCK_HIGH) ? 1'b1 : pll_lock;

  // Read mux; unmapped addresses read zero
  assign rdata_nxt = !reg_rd ? '0 :
    hit_iface ? DATA_W'(iface_r) :
    hit_lock ? DATA_W'(lock_sel_r) :
    hit_stat ? DATA_W'({lna_on, pa_on, lock_r, lna_ctrl_r, pa_ctrl_r}) :
    '0;

  // Configuration storage
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      iface_r <= RFFC_IFACE_RST;
      lock_sel_r <= RFFC_LOCK_RST;
    end
    else
    begin
      iface_r <= iface_nxt;
      lock_sel_r <= lock_sel_nxt;
    end
  end

  // Output pins and read data
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pa_ctrl_r <= 1'b0;
      lna_ctrl_r <= 1'b0;
      lock_r <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      pa_ctrl_r <= pa_ctrl_nxt;
      lna_ctrl_r <= lna_ctrl_nxt;
      lock_r <= lock_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign pa_ctrl_out = pa_ctrl_r;
  assign lna_ctrl_out = lna_ctrl_r;
  assign lock_out = lock_r;
  assign reg_rdata = rdata_r;

  // PA follows the amplifier state one edge later
  AST_PA_FOLLOW: assert property (
    @(posedge clk) disable iff (!rst_b)
    (pa_follow_sel && rst_b) |=> (pa_ctrl_out == ($past(pa_on) ?
      $past(pa_out_level) : !$past(pa_out_level))))
    else $error("pa pin does not follow amplifier");

  // LNA follows the amplifier state one edge later
  AST_LNA_FOLLOW: assert property (
    @(posedge clk) disable iff (!rst_b)
    lna_follow_sel |=> (lna_ctrl_out == ($past(lna_on) ?
      $past(lna_out_level) : !$past(lna_out_level))))
    else $error("lna pin does not follow amplifier");

  // A set level bit makes the active PA pin value high
  AST_POLARITY: assert property (
    @(posedge clk) disable iff (!rst_b)
    (pa_follow_sel && pa_on && pa_out_level) |=> pa_ctrl_out)
    else $error("pa active level wrong");

  // Static mode copies the level bits
  AST_STATIC: assert property (
    @(posedge clk) disable iff (!rst_b)
    (!pa_follow_sel && !lna_follow_sel) |=>
      (pa_ctrl_out == $past(pa_out_level)) &&
      (lna_ctrl_out == $past(lna_out_level)))
    else $error("static output not equal to level bit");

  // Lock pin forced high by the one code held for two cycles
  AST_LOCK_FORCE: assert property (
    @(posedge clk) disable iff (!rst_b)
    (lock_sel_r == RFFC_LOCK_HIGH) ##1 (lock_sel_r == RFFC_LOCK_HIGH)
      |-> lock_out)
    else $error("lock pin not forced high");

  // Lock pin forced low by the zero code
  AST_LOCK_LOW: assert property (
    @(posedge clk) disable iff (!rst_b)
    (lock_sel_r == RFFC_LOCK_LOW) |=> !lock_out)
    else $error("lock pin not forced low");

  // A write to the interface word lands in the control bits
  AST_IFACE_WRITE: assert property (
    @(posedge clk) disable iff (!rst_b)
    (reg_wr && hit_iface) |=> (iface_r == $past(reg_wdata[3:0])))
    else $error("interface word not stored");

  // Static write shows on the pin two edges after the strobe
  AST_WRITE_EFFECT: assert property (
    @(posedge clk) disable iff (!rst_b)
    (reg_wr && hit_iface && !reg_wdata[RFFC_PA_FOLLOW_BIT]) ##1 !reg_wr
      |=> (pa_ctrl_out == $past(reg_wdata[RFFC_PA_LEVEL_BIT], 2)))
    else $error("pa pin misses register write");

  // LNA level bit also sets its active value
  AST_LNA_POLARITY: assert property (
    @(posedge clk) disable iff (!rst_b)
    (lna_follow_sel && lna_on && lna_out_level) |=> lna_ctrl_out)
    else $error("lna active level wrong");

  // A cleared level bit makes the active pin value low
  AST_PA_ACT_LOW: assert property (
    @(posedge clk) disable iff (!rst_b)
    (pa_follow_sel && pa_on && !pa_out_level) |=> !pa_ctrl_out)
    else $error("pa active low level wrong");

  // PA pin copies its level bit whenever follow is off
  AST_PA_STATIC: assert property (
    @(posedge clk) disable iff (!rst_b)
    !pa_follow_sel |=> (pa_ctrl_out == $past(pa_out_level)))
    else $error("pa static output not equal to level bit");

  // LNA pin copies its level bit whenever follow is off
  AST_LNA_STATIC: assert property (
    @(posedge clk) disable iff (!rst_b)
    !lna_follow_sel |=> (lna_ctrl_out == $past(lna_out_level)))
    else $error("lna static output not equal to level bit");

  // Other lock codes pass the lock indication through
  AST_LOCK_PASS: assert property (
    @(posedge clk) disable iff (!rst_b)
    ((lock_sel_r != RFFC_LOCK_LOW) && (lock_sel_r != RFFC_LOCK_HIGH))
      |=> (lock_out == $past(pll_lock)))
    else $error("lock pin does not pass lock indication");

  // A write to the lock word lands in the source field
  AST_LOCK_WRITE: assert property (
    @(posedge clk) disable iff (!rst_b)
    (reg_wr && hit_lock) |=>
      (lock_sel_r == $past(reg_wdata[RFFC_LOCK_SEL_LSB +: RFFC_LOCK_SEL_W])))
    else $error("lock word not stored");

  // Read data stand one cycle after a read of the interface word
  AST_RD_IFACE: assert property (
    @(posedge clk) disable iff (!rst_b)
    (reg_rd && hit_iface) |=> (reg_rdata == DATA_W'($past(iface_r))))
    else $error("interface word read back wrong");

  // Read data are zero in every cycle that follows no read
  AST_RD_IDLE: assert property (
    @(posedge clk) disable iff (!rst_b)
    !reg_rd |=> (reg_rdata == '0))
    else $error("read data not zero without read");

  // LNA static write shows on its pin two edges after the strobe
  AST_LNA_WRITE_EFFECT: assert property (
    @(posedge clk) disable iff (!rst_b)
    (reg_wr && hit_iface && !reg_wdata[RFFC_LNA_FOLLOW_BIT]) ##1 !reg_wr
      |=> (lna_ctrl_out == $past(reg_wdata[RFFC_LNA_LEVEL_BIT], 2)))
    else $error("lna pin misses register write");

endmodule // rffc_outputs
`default_nettype wire

/* File: rffc_outputs_test.sv */
// Self-checking bench of the front-end control outputs
`default_nettype none
module rffc_outputs_test
  import rffc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
  logic pa_on = 0, lna_on = 0, pll_lock = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic pa_ctrl_out, lna_ctrl_out, lock_out, pa_seen, lna_seen, live;
  logic [7:0] lfsr = 8'h36; // Random source, starts at 54
  logic [2:0] exp_pin = 3'h0; // Expected lock, lna, pa pins
  logic [7:0] exp_rd = 8'h00; // Expected read word
  logic [3:0] iface_m = 4'h0, lock_m = 4'h0; // Model registers
  int err_total = 0, checked = 0;
  rffc_outputs DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pa_on(pa_on), .lna_on(lna_on),
    .pll_lock(pll_lock), .pa_ctrl_out(pa_ctrl_out),
    .lna_ctrl_out(lna_ctrl_out), .lock_out(lock_out));
  rffc_amp_model AMP (.pa_ctrl_out(pa_ctrl_out),
    .lna_ctrl_out(lna_ctrl_out), .pa_active(pa_seen),
    .lna_active(lna_seen));
  // Next random value
  function automatic logic [7:0] step(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Compare one pin level
  task automatic cmp_pin(input logic got, input logic want, input string pin);
    checked++;
    if (got !== want)
    begin
      err_total++;
      $display("Error at %0t: %s pin %b expected %b", $time, pin, got, want);
    end
  endtask
  // Compare read word
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] want);
    checked++;
    if (got !== want)
    begin
      err_total++;
      $display("Error at %0t: read %h expected %h", $time, got, want);
    end
  endtask
  // Verdict and end of run
  task automatic stop_test();
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Clock of 50 ns
  initial
  begin
    forever #25 clk = ~clk;
  end
  // Reference model: pins from config and inputs, then register update
  always @(posedge clk)
  begin
    exp_rd <= 8'h00;
    if (!rst_b)
    begin
      exp_pin <= 3'h0;
      iface_m = 4'h0;
      lock_m = 4'h0;
    end
    else
    begin
      exp_pin[0] <= iface_m[0] ? pa_on ~^ iface_m[2] : iface_m[2];
      exp_pin[1] <= iface_m[1] ? lna_on ~^ iface_m[3] : iface_m[3];
      exp_pin[2] <= lock_m == 4'h0 ? 1'b0 : lock_m == 4'h1 | pll_lock;
      if (reg_rd)
        exp_rd <= reg_addr == RFFC_IFACE_OFS ? {4'h0, iface_m} :
          reg_addr == RFFC_LOCK_OFS ? {4'h0, lock_m} :
          reg_addr == RFFC_STAT_OFS ? {3'h0, lna_on, pa_on, exp_pin} : 8'h00;
      if (reg_wr && reg_addr == RFFC_IFACE_OFS)
        iface_m = reg_wdata[3:0];
      if (reg_wr && reg_addr == RFFC_LOCK_OFS)
        lock_m = reg_wdata[3:0];
    end
  end
  // Check every settled result
  always @(negedge clk)
  begin
    cmp_pin(pa_ctrl_out, exp_pin[0], "pa");
    cmp_pin(lna_ctrl_out, exp_pin[1], "lna");
    cmp_pin(lock_out, exp_pin[2], "lock");
    cmp_pin(pa_seen, exp_pin[0], "pa stage");
    cmp_pin(lna_seen, exp_pin[1], "lna stage");
    cmp_rd(reg_rdata, exp_rd);
  end
  // Random amplifier states and register traffic, unmapped address too
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 3000; i++)
    begin
      @(posedge clk);
      lfsr = step(lfsr);
      live = i < 1500 || i > 1502; // Short reset in mid-run, strobes idle
      rst_b <= live;
      pa_on <= lfsr[0];
      lna_on <= lfsr[1];
      pll_lock <= lfsr[2];
      reg_addr <= lfsr[4] ? RFFC_IFACE_OFS : lfsr[5] ? RFFC_LOCK_OFS :
        lfsr[6] ? RFFC_STAT_OFS : 8'h05;
      reg_wdata <= step(lfsr);
      reg_wr <= lfsr[7] & lfsr[3] & live;
      reg_rd <= lfsr[7] & ~lfsr[3] & live;
    end
    stop_test();
  end
endmodule // rffc_outputs_test
`default_nettype wire

/* File: rffc_pkg.sv */
// Package: register map, field positions and reset values of the output block
`default_nettype none
package rffc_pkg;
  // Register offsets on the 8-bit address port
  localparam logic [7:0] RFFC_IFACE_OFS = 8'h01;
  localparam logic [7:0] RFFC_LOCK_OFS = 8'h1f;
  localparam logic [7:0] RFFC_STAT_OFS = 8'h20;
  // Interface control field positions
  localparam int RFFC_PA_FOLLOW_BIT = 0;
  localparam int RFFC_LNA_FOLLOW_BIT = 1;
  localparam int RFFC_PA_LEVEL_BIT = 2;
  localparam int RFFC_LNA_LEVEL_BIT = 3;
  // Lock source field position and width
  localparam int RFFC_LOCK_SEL_LSB = 0;
  localparam int RFFC_LOCK_SEL_W = 4;
  // Lock source codes
  localparam logic [3:0] RFFC_LOCK_LOW = 4'h0;
  localparam logic [3:0] RFFC_LOCK_HIGH = 4'h1;
  // Values after reset
  localparam logic [3:0] RFFC_IFACE_RST = 4'h0;
  localparam logic [3:0] RFFC_LOCK_RST = 4'h0;
endpackage
`default_nettype wire
